// File: gen_cfg_defs.vh
// Offsets, field positions, reset values and timing constants of the general configuration register
`ifndef GEN_CFG_DEFS_VH
`define GEN_CFG_DEFS_VH
`define GCFG_ADDR          7'h10
`define GCFG_RESET         24'h000004
`define GCFG_WMASK         24'hF83FFF
`define F_LPLON_HI         23
`define F_LPLON_LO         22
`define F_MCLK_HI          21
`define F_MCLK_LO          20
`define F_CHON             19
`define F_LOFF_HI          13
`define F_LOFF_LO          12
`define F_IPOL             11
`define F_IMAG_HI          10
`define F_IMAG_LO          8
`define F_VTH_HI           7
`define F_VTH_LO           6
`define F_RBIAS_HI         5
`define F_RBIAS_LO         4
`define F_RVAL_HI          3
`define F_RVAL_LO          2
`define F_POSB             1
`define F_NEGB             0
`define MODE_ON            2'h1
`define MODE_OFF           2'h0
`define CODE_R3            3'h5
// Master clock: reference 32768 Hz; accumulator increments per select code
`define REF_CLK_HZ         32768
`define MCLK_DIV_ACC_W     16
`define MCLK_INC_FULL      16'hFFFF
`define MCLK_INC_32000     16'hFA00
`define MCLK_INC_31969     16'hF9C0
`endif

// File: general_config_register.v
// General configuration register with derived master clock tick and analog control outputs
`timescale 1ns/100ps
`include "gen_cfg_defs.vh"
module general_config_register
(
   input  wire        ref_clk_i,              // Reference clock, 32.768 kHz
   input  wire        arst_n_i,               // Asynchronous reset, active low
   input  wire        reg_wr_i,               // Register write strobe, one cycle
   input  wire        reg_rd_i,               // Register read strobe, one cycle
   input  wire [6:0]  reg_addr_i,             // Register address
   input  wire [23:0] reg_wdata_i,            // Write data
   output reg  [23:0] reg_rdata_o,            // Read data, valid cycle after read
   output reg         lowpower_leadon_on_o,   // Ultra-low-power lead-on detector active
   output reg         shutdown_mode_o,        // Channel off, lead-on detector off
   output reg         channel_on_o,           // Measurement channel powered
   output reg         beat_detect_on_o,       // Beat interval detection allowed
   output reg  [1:0]  master_clk_sel_o,       // Master clock select code
   output reg         master_tick_o,          // One pulse per master clock period
   output reg  [1:0]  step_sel_o,             // Timing step group: 0=15.26us 1=15.63us 2=15.64us
   output reg         dc_leadoff_on_o,        // Lead-off detection active
   output reg         leadoff_current_polarity_o, // 0: positive up, negative down
   output reg  [2:0]  leadoff_current_level_o, // Current code, 0 when disconnected
   output reg         leadoff_sources_on_o,   // Current sources connected
   output reg  [1:0]  leadoff_threshold_sel_o, // Comparator threshold code
   output reg         res_bias_on_o,          // Resistive biasing active
   output reg  [1:0]  bias_resistor_value_o,  // Bias resistor code
   output reg         pos_input_bias_o,       // Positive input tied through resistor
   output reg         neg_input_bias_o        // Negative input tied through resistor
);

   reg  [23:0] cfg_reg;
   reg  [23:0] cfg_next;
   reg  [15:0] acc_reg;
   reg  [15:0] acc_next;
   reg         tick_next;
   reg  [15:0] inc_val;
   wire        hit;
   wire        chan_next;
   wire [1:0]  lplon_next;
   wire [1:0]  mclk_next;
   wire [1:0]  loff_next;
   wire [2:0]  imag_next;
   wire [1:0]  rbias_next;
   wire        imag_legal;

   assign hit   = (reg_addr_i == `GCFG_ADDR);
   // Field views of the value being stored this edge
   assign chan_next  = cfg_next[`F_CHON];
   assign lplon_next = cfg_next[`F_LPLON_HI:`F_LPLON_LO];
   assign mclk_next  = cfg_next[`F_MCLK_HI:`F_MCLK_LO];
   assign loff_next  = cfg_next[`F_LOFF_HI:`F_LOFF_LO];
   assign imag_next  = cfg_next[`F_IMAG_HI:`F_IMAG_LO];
   assign rbias_next = cfg_next[`F_RBIAS_HI:`F_RBIAS_LO];
   assign imag_legal = (imag_next <= `CODE_R3);                  // Codes 6 and 7 reserved

   // Next register value; unassigned bits masked off
   always @*
   begin
      cfg_next = cfg_reg;
      if (reg_wr_i && hit)
      begin
         cfg_next = reg_wdata_i & `GCFG_WMASK;
         // Bias enable only sticks when the same write turns the channel on
         if (!reg_wdata_i[`F_CHON])
            cfg_next[`F_RBIAS_HI:`F_RBIAS_LO] = `MODE_OFF;
      end
   end

   // Fractional accumulator ticks per master period from the reference
   always @*
   begin
      case (cfg_reg[`F_MCLK_HI:`F_MCLK_LO])
         2'h0:    inc_val = `MCLK_INC_FULL;                      // Every reference edge
         2'h1:    inc_val = `MCLK_INC_32000;                     // 32000/32768
         2'h2:    inc_val = `MCLK_INC_32000;                     // 32000/32768, 200 Hz progressions
         default: inc_val = `MCLK_INC_31969;                     // Approx 31968.78/32768
      endcase
   end

   // Carry out of the accumulator is the master tick; full rate bypasses it
   always @*
   begin
      if (cfg_reg[`F_MCLK_HI:`F_MCLK_LO] == 2'h0)
      begin
         acc_next  = 16'h0000;
         tick_next = 1'b1;
      end
      else
      begin
         {tick_next, acc_next} = {1'b0, acc_reg} + {1'b0, inc_val};
      end
   end

   // Each decoded output below has a flop of its own, fed from the value being stored,
   // so every decode changes at the very edge that takes the write.
   // Costs a few flops; only master_tick_o, built from cfg_reg, lags the register by a cycle.

   // Stored configuration word
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         cfg_reg <= `GCFG_RESET;
      else
         cfg_reg <= cfg_next;
   end

   // Fractional accumulator for the divided master clock
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         acc_reg <= 16'h0000;
      else
         acc_reg <= acc_next;
   end

   // Master tick, one pulse per master clock period
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         master_tick_o <= 1'b0;
      else
         master_tick_o <= tick_next;
   end

   // Read data held until the next read; unmapped addresses read zero
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         reg_rdata_o <= 24'h000000;
      else if (reg_rd_i)
         reg_rdata_o <= hit ? cfg_reg : 24'h000000;
   end

   // Lead-on detector only while the channel is off
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         lowpower_leadon_on_o <= 1'b0;
      else
         lowpower_leadon_on_o <= !chan_next &&
                                 (lplon_next == `MODE_ON);
   end

   // Plain shutdown is the other channel-off mode
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         shutdown_mode_o <= 1'b1;
      else
         shutdown_mode_o <= !chan_next &&
                            (lplon_next != `MODE_ON);
   end

   // Measurement channel power
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         channel_on_o <= 1'b0;
      else
         channel_on_o <= chan_next;
   end

   // Beat detection may run only with the channel on
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         beat_detect_on_o <= 1'b0;
      else
         beat_detect_on_o <= chan_next;
   end

   // Master clock select code
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         master_clk_sel_o <= 2'h0;
      else
         master_clk_sel_o <= mclk_next;
   end

   // Step group covers timing, beat and calibration steps alike;
   // codes 01 and 10 share one group since both run at 32000 Hz
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         step_sel_o <= 2'h0;
      else
         case (mclk_next)
            2'h0:    step_sel_o <= 2'h0;
            2'h3:    step_sel_o <= 2'h2;
            default: step_sel_o <= 2'h1;
         endcase
   end

   // Lead-off detection needs an active channel
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         dc_leadoff_on_o <= 1'b0;
      else
         dc_leadoff_on_o <= chan_next &&
                            (loff_next == `MODE_ON);
   end

   // Lead-off current polarity
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         leadoff_current_polarity_o <= 1'b0;
      else
         leadoff_current_polarity_o <= cfg_next[`F_IPOL];
   end

   // Reserved current codes treated as disconnected, so a bad
   // host write can never drive an undefined current into a lead
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         leadoff_current_level_o <= 3'h0;
      else if (imag_legal)
         leadoff_current_level_o <= imag_next;
      else
         leadoff_current_level_o <= 3'h0;
   end

   // Sources connected only for a legal nonzero current code
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         leadoff_sources_on_o <= 1'b0;
      else
         leadoff_sources_on_o <= (imag_next != 3'h0) &&
                                 imag_legal;
   end

   // Comparator threshold code
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         leadoff_threshold_sel_o <= 2'h0;
      else
         leadoff_threshold_sel_o <= cfg_next[`F_VTH_HI:`F_VTH_LO];
   end

   // Resistive biasing needs the channel on as well
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         res_bias_on_o <= 1'b0;
      else
         res_bias_on_o <= chan_next &&
                          (rbias_next == `MODE_ON);
   end

   // Bias resistor code, default 100 megaohm setting
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         bias_resistor_value_o <= 2'h1;
      else
         bias_resistor_value_o <= cfg_next[`F_RVAL_HI:`F_RVAL_LO];
   end

   // Positive input bias switch
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pos_input_bias_o <= 1'b0;
      else
         pos_input_bias_o <= cfg_next[`F_POSB];
   end

   // Negative input bias switch
   always @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         neg_input_bias_o <= 1'b0;
      else
         neg_input_bias_o <= cfg_next[`F_NEGB];
   end

endmodule

// File: gcr_asserts.sv
// Port-level checks of the general configuration register
`timescale 1ns/100ps
`include "gen_cfg_defs.vh"
module gcr_asserts
(
   input wire        ref_clk_i,               // Clock
   input wire        arst_n_i,                // Reset, active low
   input wire        reg_wr_i,                // Write strobe
   input wire [6:0]  reg_addr_i,              // Address
   input wire [23:0] reg_wdata_i,             // Write data
   input wire        lowpower_leadon_on_o,    // Lead-on mode
   input wire        shutdown_mode_o,         // Shutdown mode
   input wire        channel_on_o,            // Channel
   input wire [1:0]  master_clk_sel_o,        // Clock select
   input wire        master_tick_o,           // Master tick
   input wire [1:0]  step_sel_o,              // Step group
   input wire        dc_leadoff_on_o,         // Lead-off
   input wire [2:0]  leadoff_current_level_o, // Current code
   input wire        leadoff_sources_on_o,    // Sources
   input wire        res_bias_on_o            // Bias
);
   wire [23:0] d = reg_wdata_i;
   reg  [6:0]  run_reg;
   // Tick run length; a divided clock must skip a tick about every 40 to 43 cycles
   always @(posedge ref_clk_i or negedge arst_n_i)
      if (!arst_n_i)
         run_reg <= 7'h00;
      else
         run_reg <= (master_tick_o && master_clk_sel_o != 2'h0) ? run_reg + 7'h01 : 7'h00;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_wr; reg_wr_i && reg_addr_i == `GCFG_ADDR; endsequence
   sequence s_sel0; master_clk_sel_o == 2'h0; endsequence
   chk_chan_follow: assert property (s_wr |=> channel_on_o == $past(d[19]))
      else $error("channel enable not taken");
   chk_bias_gate: assert property (s_wr |=> res_bias_on_o == $past(d[19] && d[5:4] == 2'h1))
      else $error("bias gating wrong");
   chk_leadoff_gate: assert property (s_wr |=> dc_leadoff_on_o == $past(d[19] && d[13:12] == 2'h1))
      else $error("lead-off gating wrong");
   chk_mode_onehot: assert property ($onehot({channel_on_o, lowpower_leadon_on_o, shutdown_mode_o}))
      else $error("power mode not exclusive");
   chk_level_src: assert property (leadoff_sources_on_o == (leadoff_current_level_o != 3'h0)
      && leadoff_current_level_o <= 3'h5)
      else $error("current source state wrong");
   chk_step_map: assert property (step_sel_o == (master_clk_sel_o == 2'h0 ? 2'h0 :
      (master_clk_sel_o == 2'h3 ? 2'h2 : 2'h1)))
      else $error("step group wrong");
   chk_tick_full: assert property (s_sel0 [*2] |-> master_tick_o)
      else $error("full rate tick missing");
   chk_tick_drop: assert property (run_reg < 7'h32)
      else $error("divided tick never drops");
endmodule
bind general_config_register gcr_asserts i_chk (.*);

// File: host_model.sv
// Host side of the register port, driving at the falling edge
`timescale 1ns/100ps
module host_model
(
   input  wire        ref_clk_i,          // Clock
   input  wire [23:0] reg_rdata_i,        // Read data
   output reg         reg_wr_o = 1'b0,    // Write strobe
   output reg         reg_rd_o = 1'b0,    // Read strobe
   output reg  [6:0]  reg_addr_o = 7'h00, // Address
   output reg  [23:0] reg_wdata_o = 24'h0 // Write data
);
   // One-cycle write; data inverted after so stale words never pass
   task wr(input [6:0] a, input [23:0] v);
      begin
         @(negedge ref_clk_i);
         {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, v};
         @(negedge ref_clk_i);
         {reg_wr_o, reg_wdata_o} = {1'b0, ~v};
      end
   endtask
   // One-cycle read; answer settled one edge later
   task rd(input [6:0] a, output [23:0] q);
      begin
         @(negedge ref_clk_i);
         {reg_rd_o, reg_addr_o} = {1'b1, a};
         @(negedge ref_clk_i);
         reg_rd_o = 1'b0;
         q = reg_rdata_i;
      end
   endtask
endmodule

// File: testbench.sv
// Self-checking bench of the general configuration register
`timescale 1ns/100ps
`include "gen_cfg_defs.vh"
module testbench;
   localparam [167:0] CORNERS = {24'h080011, 24'h000012, 24'h400000, 24'h7FDDDB, 24'h200000, 24'h100000, 24'h001400};
   reg         ref_clk_i = 1'b0;    // Clock
   reg         arst_n_i = 1'b0;     // Reset, active low
   wire        wr_w, rd_w;          // Strobes
   wire [6:0]  addr_w;              // Address
   wire [23:0] wdata_w, rdata_w;    // Data
   wire [20:0] o_w;                 // Decoded outputs
   reg  [31:0] lfsr_reg = 32'h108E; // Stimulus state
   reg  [23:0] d, got;
   integer     error_cnt = 0, tests_run = 0, i;
   host_model i_host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata_w), .reg_wr_o(wr_w), .reg_rd_o(rd_w),
      .reg_addr_o(addr_w), .reg_wdata_o(wdata_w));
   general_config_register i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr_w),
      .reg_rd_i(rd_w), .reg_addr_i(addr_w), .reg_wdata_i(wdata_w), .reg_rdata_o(rdata_w),
      .lowpower_leadon_on_o(o_w[20]), .shutdown_mode_o(o_w[19]), .channel_on_o(o_w[18]),
      .beat_detect_on_o(o_w[17]), .master_clk_sel_o(o_w[16:15]), .master_tick_o(), .step_sel_o(o_w[14:13]),
      .dc_leadoff_on_o(o_w[12]), .leadoff_current_polarity_o(o_w[11]), .leadoff_current_level_o(o_w[10:8]),
      .leadoff_sources_on_o(o_w[7]), .leadoff_threshold_sel_o(o_w[6:5]), .res_bias_on_o(o_w[4]),
      .bias_resistor_value_o(o_w[3:2]), .pos_input_bias_o(o_w[1]), .neg_input_bias_o(o_w[0]));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Stored word: free bits dropped, bias cleared unless the same write enables the channel
   function [23:0] exp_reg(input [23:0] r);
      exp_reg = r & `GCFG_WMASK & ~{18'h0, ~r[19], ~r[19], 4'h0};
   endfunction
   function [20:0] exp_out(input [23:0] r);
      exp_out = {~r[19] & (r[23:22] == 2'h1), ~r[19] & (r[23:22] != 2'h1), r[19], r[19], r[21:20],
         (r[21:20] == 2'h0) ? 2'h0 : ((r[21:20] == 2'h3) ? 2'h2 : 2'h1), r[19] & (r[13:12] == 2'h1), r[11],
         (r[10:8] <= 3'h5) ? r[10:8] : 3'h0, r[10:8] != 3'h0 && r[10:8] <= 3'h5, r[7:6],
         r[19] & (r[5:4] == 2'h1), r[3:0]};
   endfunction
   task cmp(input [23:0] g, input [23:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e)
         begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task conclude;
      begin
         if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial forever #20 ref_clk_i = ~ref_clk_i;
   // Corner words first, then masked random words; idle gaps let the tick checks run
   initial
   begin
      repeat (12) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      cmp({3'h0, o_w}, {3'h0, exp_out(`GCFG_RESET)});
      i_host.rd(`GCFG_ADDR, got);
      cmp(got, `GCFG_RESET);
      for (i = 0; i < 60; i = i + 1)
      begin
         lfsr_reg = lfsr(lfsr_reg);
         d = (i < 7) ? CORNERS[i*24 +: 24] : lfsr_reg[23:0] & 24'h7FDBD7;
         i_host.wr(`GCFG_ADDR, d);
         i_host.wr(7'h11, ~d);
         cmp({3'h0, o_w}, {3'h0, exp_out(exp_reg(d))});
         i_host.rd(`GCFG_ADDR, got);
         cmp(got, exp_reg(d));
         i_host.rd(7'h11, got);
         cmp(got, 24'h000000);
         repeat (lfsr_reg[5:0]) @(negedge ref_clk_i);
      end
      conclude;
   end
endmodule
